// ### design/pclr_map.svh
// Constants for the carrier, latency and reset block
`ifndef PCLR_MAP_SVH
`define PCLR_MAP_SVH
`define PCLR_SYS_PERIOD_PS 10000
`define PCLR_BIT_100_PS 10000
`define PCLR_BIT_10_PS 100000
`define PCLR_RX_PIPE_MII 4
`define PCLR_RX_PIPE_STREAM 2
`define PCLR_CRS_ON_DELAY 7
`define PCLR_COL_ON_DELAY 3
`define PCLR_CRS_OFF_DELAY 2
`define PCLR_CODE_J 5'h18
`define PCLR_CODE_K 5'h11
`define PCLR_CODE_T 5'h0D
`define PCLR_CODE_R 5'h07
`define PCLR_NIB_J 4'h5
`define PCLR_NIB_K 4'h5
`define PCLR_POR_MIN_MS 40
`define PCLR_POR_TYP_MS 45
`define PCLR_HWRST_MIN_NS 500
`define PCLR_ISOLATE_NS 60
`define PCLR_TXCLK_VALID_MS 35
`define PCLR_TXCLK_DIV 2
`endif

// ### design/pclr_pkg.sv
// Types for the carrier, latency and reset block
package pclr_pkg;
	typedef enum logic [1:0] {
		PCLR_RST_HOLD = 2'b00,
		PCLR_RST_WAIT = 2'b01,
		PCLR_RST_RUN = 2'b10
	} pclr_rst_state_t;
	typedef enum logic [1:0] {
		PCLR_RX_IDLE = 2'b00,
		PCLR_RX_FRAME = 2'b01,
		PCLR_RX_END = 2'b10
	} pclr_rx_state_t;
	typedef struct packed {
		logic speed_100;
		logic full_duplex;
		logic stream_mode;
	} pclr_mode_t;
	typedef struct packed {
		logic valid;
		logic [3:0] data;
	} pclr_nib_t;
endpackage : pclr_pkg

// ### design/pclr_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module pclr_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_sync_out;
	initial begin
		if (WIDTH < 1) $error("WIDTH must be positive");
	end
	always_comb begin
		next_stage1 = async_in;
		next_sync_out = stage1;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= next_stage1;
			sync_out <= next_sync_out;
		end
	end
endmodule : pclr_sync

// ### design/pclr_delay.sv
// Fixed-length shift delay line
`timescale 1ns/1ps
module pclr_delay #(
	parameter int WIDTH = 5,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] taps [DEPTH];
	logic [WIDTH-1:0] next_taps [DEPTH];
	initial begin
		if (DEPTH < 1 || WIDTH < 1) $error("DEPTH and WIDTH must be positive");
	end
	always_comb begin
		next_taps[0] = din;
		for (int i = 1; i < DEPTH; i++) begin
			next_taps[i] = taps[i-1];
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				taps[i] <= '0;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				taps[i] <= next_taps[i];
			end
		end
	end
	assign dout = taps[DEPTH-1];
endmodule : pclr_delay

// ### design/phy_carrier_latency_reset.sv
// Carrier sense, collision, receive latency and reset sequencing of the transceiver
`timescale 1ns/1ps
`include "pclr_map.svh"
module phy_carrier_latency_reset #(
	parameter int POR_CYCLES = (`PCLR_POR_TYP_MS * 1000000) / (`PCLR_SYS_PERIOD_PS / 1000),
	parameter int TXCLK_CYCLES = (`PCLR_TXCLK_VALID_MS * 1000000) / (`PCLR_SYS_PERIOD_PS / 1000),
	parameter int HWRST_MIN_CYCLES = (`PCLR_HWRST_MIN_NS * 1000 + `PCLR_SYS_PERIOD_PS - 1) / `PCLR_SYS_PERIOD_PS
) (
	// System clock and power-good reset
	input wire logic clock,
	input wire logic rst_n,
	// Hardware reset pin, active low
	input wire logic hw_reset_low,
	// Mode straps
	input wire pclr_pkg::pclr_mode_t mode,
	// Line side: recovered 125 MHz clock and 5-bit code groups
	input wire logic line_clock,
	input wire logic [4:0] line_receive_pair,
	// MII transmit side
	output logic txclk,
	input wire logic txen,
	// MII receive side, on the line clock
	output logic rxdv,
	output logic [3:0] rxd,
	// Carrier and collision
	output logic crs,
	output logic col,
	// Status
	output logic isolate,
	output logic ready
);
	localparam int POR_MIN_CYCLES = (`PCLR_POR_MIN_MS * 1000000) / (`PCLR_SYS_PERIOD_PS / 1000);
	localparam int HWRST_CNT_W = 12;
	initial begin
		if (POR_CYCLES < 1 || TXCLK_CYCLES < 1 || HWRST_MIN_CYCLES < 1) $error("cycle counts must be positive");
		if (HWRST_MIN_CYCLES >= (1 << HWRST_CNT_W)) $error("HWRST_MIN_CYCLES too large");
	end

	function automatic logic is_code(input logic [4:0] code, input logic [4:0] ref_code);
		is_code = (code == ref_code);
	endfunction : is_code

	// Hardware reset synchroniser and pulse width qualification
	logic hw_low_sync;
	logic hw_rst_sync;
	pclr_sync #(.WIDTH(1)) u_hw_sync (
		.clock(clock),
		.rst_n(rst_n),
		.async_in(~hw_reset_low),
		.sync_out(hw_rst_sync)
	);
	assign hw_low_sync = hw_rst_sync;
	logic [HWRST_CNT_W-1:0] low_cnt;
	logic [HWRST_CNT_W-1:0] next_low_cnt;
	logic rst_accept;
	logic next_rst_accept;
	always_comb begin
		next_low_cnt = low_cnt;
		next_rst_accept = rst_accept;
		if (hw_low_sync) begin
			if (low_cnt != HWRST_CNT_W'(HWRST_MIN_CYCLES)) begin
				next_low_cnt = low_cnt + 1'b1;
			end else begin
				next_rst_accept = 1'b1;
			end
		end else begin
			next_low_cnt = '0;
			next_rst_accept = 1'b0;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt <= '0;
			rst_accept <= 1'b0;
		end else begin
			low_cnt <= next_low_cnt;
			rst_accept <= next_rst_accept;
		end
	end

	// Reset sequencer: power-on wait then run
	pclr_pkg::pclr_rst_state_t rst_state;
	pclr_pkg::pclr_rst_state_t next_rst_state;
	logic [31:0] wait_cnt;
	logic [31:0] next_wait_cnt;
	logic por_done;
	logic next_por_done;
	always_comb begin
		next_rst_state = rst_state;
		next_wait_cnt = wait_cnt;
		next_por_done = por_done;
		case (rst_state)
			pclr_pkg::PCLR_RST_HOLD: begin
				next_wait_cnt = '0;
				if (!hw_low_sync) begin
					next_rst_state = pclr_pkg::PCLR_RST_WAIT;
				end
			end
			pclr_pkg::PCLR_RST_WAIT: begin
				next_wait_cnt = wait_cnt + 1'b1;
				if (!por_done && wait_cnt >= 32'(POR_CYCLES - 1)) begin
					next_por_done = 1'b1;
					next_rst_state = pclr_pkg::PCLR_RST_RUN;
				end else if (por_done && wait_cnt >= 32'(TXCLK_CYCLES - 1)) begin
					next_rst_state = pclr_pkg::PCLR_RST_RUN;
				end
			end
			pclr_pkg::PCLR_RST_RUN: begin
				next_wait_cnt = '0;
			end
			default: begin
				next_rst_state = pclr_pkg::PCLR_RST_HOLD;
			end
		endcase
		if (rst_accept) begin
			next_rst_state = pclr_pkg::PCLR_RST_HOLD;
			next_wait_cnt = '0;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_state <= pclr_pkg::PCLR_RST_WAIT;
			wait_cnt <= '0;
			por_done <= 1'b0;
		end else begin
			rst_state <= next_rst_state;
			wait_cnt <= next_wait_cnt;
			por_done <= next_por_done;
		end
	end
	assign ready = (rst_state == pclr_pkg::PCLR_RST_RUN);
	// Isolation starts as soon as the reset pin is seen low
	assign isolate = ~ready | hw_low_sync;

	// Transmit clock divider, gated until valid
	logic [3:0] div_cnt;
	logic [3:0] next_div_cnt;
	logic txclk_q;
	logic next_txclk_q;
	always_comb begin
		next_div_cnt = div_cnt + 1'b1;
		next_txclk_q = txclk_q;
		if (div_cnt == 4'(`PCLR_TXCLK_DIV - 1)) begin
			next_div_cnt = '0;
			next_txclk_q = ~txclk_q;
		end
		if (!ready) begin
			next_txclk_q = 1'b0;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= '0;
			txclk_q <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			txclk_q <= next_txclk_q;
		end
	end
	assign txclk = txclk_q;

	// Transmit enable, sampled on the system clock
	logic txen_s;
	pclr_sync #(.WIDTH(1)) u_txen_sync (
		.clock(clock),
		.rst_n(rst_n),
		.async_in(txen),
		.sync_out(txen_s)
	);

	// Mode straps into both domains
	pclr_pkg::pclr_mode_t mode_s;
	pclr_pkg::pclr_mode_t mode_l;
	pclr_sync #(.WIDTH(3)) u_mode_sync (
		.clock(clock),
		.rst_n(rst_n),
		.async_in(mode),
		.sync_out(mode_s)
	);
	pclr_sync #(.WIDTH(3)) u_mode_lsync (
		.clock(line_clock),
		.rst_n(rst_n),
		.async_in(mode),
		.sync_out(mode_l)
	);

	// Transmit activity into the line domain for collision
	logic txen_l;
	pclr_sync #(.WIDTH(1)) u_txen_lsync (
		.clock(line_clock),
		.rst_n(rst_n),
		.async_in(txen_s & ~mode_s.full_duplex),
		.sync_out(txen_l)
	);

	// Line receive: /J/ /T/ detection on the 125 MHz symbol clock (one 5-bit code group per tick)
	pclr_pkg::pclr_rx_state_t rx_state;
	pclr_pkg::pclr_rx_state_t next_rx_state;
	logic [4:0] code_q;
	logic [4:0] next_code_q;
	logic rx_carrier;
	logic next_rx_carrier;
	logic col_l;
	logic next_col_l;
	pclr_pkg::pclr_nib_t nib_in;
	always_comb begin
		next_rx_state = rx_state;
		next_code_q = line_receive_pair;
		next_rx_carrier = rx_carrier;
		next_col_l = col_l;
		nib_in.valid = 1'b0;
		nib_in.data = 4'h0;
		case (rx_state)
			pclr_pkg::PCLR_RX_IDLE: begin
				if (mode_l.speed_100 && is_code(code_q, `PCLR_CODE_J)) begin
					next_rx_state = pclr_pkg::PCLR_RX_FRAME;
					next_rx_carrier = 1'b1;
					next_col_l = txen_l;
					nib_in.valid = 1'b1;
					nib_in.data = `PCLR_NIB_J;
				end
			end
			pclr_pkg::PCLR_RX_FRAME: begin
				nib_in.valid = 1'b1;
				nib_in.data = code_q[3:0];
				if (is_code(code_q, `PCLR_CODE_T)) begin
					next_rx_state = pclr_pkg::PCLR_RX_END;
					nib_in.valid = 1'b0;
				end
			end
			pclr_pkg::PCLR_RX_END: begin
				next_rx_state = pclr_pkg::PCLR_RX_IDLE;
				next_rx_carrier = 1'b0;
				next_col_l = 1'b0;
			end
			default: begin
				next_rx_state = pclr_pkg::PCLR_RX_IDLE;
			end
		endcase
		if (rx_state == pclr_pkg::PCLR_RX_FRAME && txen_l) begin
			next_col_l = 1'b1;
		end
		if (!mode_l.speed_100) begin
			next_col_l = 1'b0;
		end
	end
	always_ff @(posedge line_clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_state <= pclr_pkg::PCLR_RX_IDLE;
			code_q <= '0;
			rx_carrier <= 1'b0;
			col_l <= 1'b0;
		end else begin
			rx_state <= next_rx_state;
			code_q <= next_code_q;
			rx_carrier <= next_rx_carrier;
			col_l <= next_col_l;
		end
	end

	// Receive nibble latency: MII path longer than stream path
	pclr_pkg::pclr_nib_t nib_mii;
	pclr_pkg::pclr_nib_t nib_str;
	pclr_delay #(.WIDTH(5), .DEPTH(`PCLR_RX_PIPE_MII)) u_mii_pipe (
		.clock(line_clock),
		.rst_n(rst_n),
		.din(nib_in),
		.dout(nib_mii)
	);
	pclr_delay #(.WIDTH(5), .DEPTH(`PCLR_RX_PIPE_STREAM)) u_str_pipe (
		.clock(line_clock),
		.rst_n(rst_n),
		.din(nib_in),
		.dout(nib_str)
	);
	logic next_rxdv;
	logic [3:0] next_rxd;
	always_comb begin
		if (mode_l.stream_mode) begin
			next_rxdv = nib_str.valid;
			next_rxd = nib_str.data;
		end else begin
			next_rxdv = nib_mii.valid;
			next_rxd = nib_mii.data;
		end
	end
	always_ff @(posedge line_clock or negedge rst_n) begin
		if (!rst_n) begin
			rxdv <= 1'b0;
			rxd <= '0;
		end else begin
			rxdv <= next_rxdv;
			rxd <= next_rxd;
		end
	end

	// Line carrier and collision into the system domain
	logic rx_carrier_s;
	logic col_s;
	pclr_sync #(.WIDTH(2)) u_line_sync (
		.clock(clock),
		.rst_n(rst_n),
		.async_in({rx_carrier, col_l}),
		.sync_out({rx_carrier_s, col_s})
	);
	// Line carrier held back so it rises and falls inside its window
	logic [1:0] line_on;
	logic [1:0] line_hold;
	pclr_delay #(.WIDTH(2), .DEPTH(`PCLR_CRS_ON_DELAY)) u_on_pipe (
		.clock(clock),
		.rst_n(rst_n),
		.din({rx_carrier_s, col_s}),
		.dout(line_on)
	);
	pclr_delay #(.WIDTH(2), .DEPTH(`PCLR_CRS_OFF_DELAY)) u_hold_pipe (
		.clock(clock),
		.rst_n(rst_n),
		.din(line_on),
		.dout(line_hold)
	);

	// Carrier sense and collision outputs
	logic next_crs;
	logic next_col;
	always_comb begin
		next_crs = line_on[1] | line_hold[1];
		if (!mode_s.full_duplex && txen_s) begin
			next_crs = 1'b1;
		end
		next_col = (line_on[0] | line_hold[0]) & ~mode_s.full_duplex;
		if (isolate) begin
			next_crs = 1'b0;
			next_col = 1'b0;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			crs <= 1'b0;
			col <= 1'b0;
		end else begin
			crs <= next_crs;
			col <= next_col;
		end
	end
endmodule : phy_carrier_latency_reset

// ### tb/pclr_monitor.sv
// Port checks for the carrier, latency and reset block
`timescale 1ns/1ps
module pclr_monitor #(
	parameter int POR_CYCLES = 200,
	parameter int TXCLK_CYCLES = 100
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Inputs
	input wire logic hw_reset_low,
	input wire pclr_pkg::pclr_mode_t mode,
	input wire logic txen,
	// Outputs
	input wire logic txclk,
	input wire logic rxdv,
	input wire logic crs,
	input wire logic col,
	input wire logic isolate,
	input wire logic ready
);
	logic [31:0] wait_cnt;
	logic [31:0] next_wait_cnt;
	logic hd100;
	logic hd10;
	assign hd100 = ready && mode.speed_100 && !mode.full_duplex;
	assign hd10 = ready && !mode.speed_100 && !mode.full_duplex;
	always_comb begin
		next_wait_cnt = (ready || !hw_reset_low) ? 32'h0 : wait_cnt + 32'h1;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt <= 32'h0;
		end else begin
			wait_cnt <= next_wait_cnt;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	crs_on_fast_a: assert property ($rose(txen) && hd100 |-> ##[1:4] crs) else $error("crs late");
	crs_off_fast_a: assert property ($fell(txen) && hd100 && !rxdv |-> ##[1:4] !crs) else $error("crs stays");
	crs_on_slow_a: assert property ($rose(txen) && hd10 |-> ##[1:20] crs) else $error("crs late");
	crs_off_slow_a: assert property ($fell(txen) && hd10 && !rxdv |-> ##[1:40] !crs) else $error("crs stays");
	crs_full_a: assert property ($rose(txen) && mode.full_duplex && !crs && !rxdv |-> !crs [*4])
		else $error("crs follows txen");
	iso_quiet_a: assert property (isolate |=> !crs && !col) else $error("carrier while isolated");
	pin_iso_a: assert property ($fell(hw_reset_low) |-> ##[0:5] isolate) else $error("no isolation");
	col_mode_a: assert property (col |-> mode.speed_100 && !mode.full_duplex) else $error("col bad mode");
	txclk_idle_a: assert property (!ready && !$past(ready) |-> !txclk) else $error("txclk early");
	wait_max_a: assert property (wait_cnt <= POR_CYCLES + TXCLK_CYCLES + 8) else $error("ready late");
	wait_min_a: assert property ($rose(ready) |-> wait_cnt >= TXCLK_CYCLES) else $error("ready early");
	cover property ($rose(crs));
	cover property ($rose(col));
	cover property ($rose(ready));
endmodule : pclr_monitor
bind phy_carrier_latency_reset pclr_monitor #(.POR_CYCLES(POR_CYCLES), .TXCLK_CYCLES(TXCLK_CYCLES)) mon (
	.clock(clock), .rst_n(rst_n), .hw_reset_low(hw_reset_low), .mode(mode), .txen(txen), .txclk(txclk),
	.rxdv(rxdv), .crs(crs), .col(col), .isolate(isolate), .ready(ready)
);

// ### tb/pclr_mac.sv
// Behavioural MAC that raises transmit enable on request
`timescale 1ns/1ps
module pclr_mac (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Request and device status
	input wire logic tx_req,
	input wire logic ready,
	// Transmit enable
	output logic txen
);
	logic next_txen;
	always_comb begin
		next_txen = tx_req && ready;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			txen <= 1'b0;
		end else begin
			txen <= next_txen;
		end
	end
endmodule : pclr_mac

// ### tb/phy_carrier_latency_reset_test.sv
// Testbench for the carrier, latency and reset block
`timescale 1ns/1ps
module phy_carrier_latency_reset_test;
	localparam int POR = 200;
	localparam int TXC = 100;
	logic clock = 1'b0;
	logic line_clock = 1'b0;
	logic rst_n = 1'b0;
	logic hw_reset_low = 1'b1;
	pclr_pkg::pclr_mode_t mode = 3'h4;
	logic [4:0] lrp = 5'h1F;
	logic tx_req = 1'b0;
	logic txen, txclk, rxdv, crs, col, isolate, ready;
	logic [3:0] rxd;
	int n_errors = 0;
	int samples_checked = 0;
	int k;
	realtime t0;
	int rows [4][4] = '{'{1, 0, 40, 40}, '{0, 0, 200, 400}, '{1, 1, 0, 0}, '{0, 1, 0, 0}};
	always #5 clock = ~clock;
	always #6 line_clock = ~line_clock;
	phy_carrier_latency_reset #(.POR_CYCLES(POR), .TXCLK_CYCLES(TXC)) dut (.clock(clock), .rst_n(rst_n),
		.hw_reset_low(hw_reset_low), .mode(mode), .line_clock(line_clock), .line_receive_pair(lrp),
		.txclk(txclk), .txen(txen), .rxdv(rxdv), .rxd(rxd), .crs(crs), .col(col), .isolate(isolate), .ready(ready));
	pclr_mac mac (.clock(clock), .rst_n(rst_n), .tx_req(tx_req), .ready(ready), .txen(txen));
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	function logic sig(input int w);
		case (w)
			0: return crs;
			1: return !crs;
			2: return col;
			3: return !col;
			4: return rxdv && rxd == 4'h5;
			default: return isolate;
		endcase
	endfunction : sig
	// Waits for a condition and checks it came between lo and hi ns after t0
	task lat(input int w, input int lo, input int hi, input string nm);
		k = 0;
		while (sig(w) !== 1'b1 && k < 2000) begin
			#1;
			k++;
		end
		chk(nm, ($realtime - t0 >= lo && $realtime - t0 <= hi) ? 32'h1 : 32'h0, 32'h1);
	endtask : lat
	task cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc
	task put(input logic [4:0] c);
		@(posedge line_clock);
		lrp <= c;
	endtask : put
	task rx_on;
		put(5'h18);
		t0 = $realtime;
		fork
			put(5'h0E);
		join_none
	endtask : rx_on
	task rx_off;
		put(5'h0D);
		t0 = $realtime;
		fork
			begin
				put(5'h07);
				put(5'h1F);
			end
		join_none
	endtask : rx_off
	task conclude;
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude
	initial begin
		#300000;
		n_errors++;
		conclude();
	end
	initial begin
		cyc(5);
		chk("crs_rst", {31'h0, crs}, 32'h0);
		chk("txclk_rst", {31'h0, txclk}, 32'h0);
		cyc(1);
		rst_n <= 1'b1;
		k = 0;
		while (ready !== 1'b1 && k < 1000) begin
			cyc(1);
			k++;
		end
		chk("por_wait", (k >= POR && k <= POR + 8) ? 32'h1 : 32'h0, 32'h1);
		#1;
		k = txclk;
		#20;
		chk("txclk_run", {31'h0, txclk}, {31'h0, ~k[0]});
		$display("test power on done");
		for (int i = 0; i < 4; i++) begin
			cyc(1);
			mode.speed_100 <= rows[i][0][0];
			mode.full_duplex <= rows[i][1][0];
			cyc(6);
			tx_req <= 1'b1;
			@(posedge txen);
			t0 = $realtime;
			if (rows[i][2] > 0) begin
				lat(0, 0, rows[i][2], "crs_on");
			end else begin
				#55;
				chk("crs_full", {31'h0, crs}, 32'h0);
			end
			cyc(1);
			tx_req <= 1'b0;
			@(negedge txen);
			t0 = $realtime;
			lat(1, 0, rows[i][3], "crs_off");
			$display("test row %0d done", i);
		end
		cyc(1);
		mode <= 3'h4;
		cyc(6);
		rx_on();
		lat(4, 0, 170, "rxd_j_mii");
		lat(0, 100, 140, "crs_rx_on");
		cyc(10);
		rx_off();
		lat(1, 130, 180, "crs_rx_off");
		cyc(1);
		mode <= 3'h5;
		cyc(6);
		rx_on();
		lat(4, 0, 90, "rxd_j_stream");
		cyc(10);
		rx_off();
		cyc(1);
		mode <= 3'h6;
		cyc(20);
		rx_on();
		lat(0, 100, 140, "crs_fd_rx");
		cyc(10);
		rx_off();
		cyc(1);
		mode <= 3'h4;
		cyc(20);
		$display("test receive done");
		tx_req <= 1'b1;
		cyc(8);
		rx_on();
		lat(2, 90, 130, "col_on");
		cyc(10);
		rx_off();
		lat(3, 130, 180, "col_off");
		cyc(2);
		tx_req <= 1'b0;
		cyc(10);
		$display("test collision done");
		t0 = $realtime;
		hw_reset_low <= 1'b0;
		lat(5, 0, 60, "isolate");
		cyc(60);
		chk("ready_drop", {31'h0, ready}, 32'h0);
		hw_reset_low <= 1'b1;
		k = 0;
		while (ready !== 1'b1 && k < 1000) begin
			cyc(1);
			k++;
		end
		chk("txclk_wait", (k >= TXC && k <= TXC + 8) ? 32'h1 : 32'h0, 32'h1);
		$display("test hardware reset done");
		conclude();
	end
endmodule : phy_carrier_latency_reset_test
